/* rtl/ctt_tick_timer_halt_wake.sv */
// Tick timer with halt entry, held wake requests, stop indication and warm-up
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// Operation
// RULE1: Selector codes 00..11 give tick intervals of 2^14..2^11 slow clocks.
// RULE2: Run bit low stops and clears the counter; high counts slow clock.
// RULE3: Software stops the tick timer before entering light standby.
// RULE4: Wakes during the five prescaler clock entry are held pending, except operating standby; the code holds them in stop and light modes only.
// RULE5: A wake after full entry ends halt; higher priority pending served first.
// RULE6: Stop output rises for stop mode halt unless drive during stop is set.
// RULE7: Leaving stop always runs warm-up before the system clock returns.
// RULE8: Undefined register bits read back as an unspecified value, here zero.
// RULE9: Each elapsed interval while running raises the tick request, a wake source.
// RULE10: Software writes zero to bit 7; all control bits reset to zero.
module ctt_tick_timer_halt_wake import ctt_pkg::*; #(
	parameter logic [15:0] WARMUP_CYCLES = WARMUP_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// Register port
	input  wire logic [11:0] REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	// Slow clock pin
	input  wire logic        SLOW_CLK,
	// Halt sequencer
	input  wire logic        HALT_EXEC,
	input  wire logic        PRESCALER_TICK,
	output logic             STOP,
	output logic             SYS_CLK_EN,
	// Interrupt controller
	input  wire logic [5:0]  WAKE_IN,
	output logic             TICK_INTERRUPT,
	output logic             WAKE_SERVICE_REQ,
	output logic      [2:0]  WAKE_SERVICE_ID,
	input  wire logic        WAKE_SERVICE_ACK,
	output logic             IRQ
);
	logic                slow_s1_q;
	logic                slow_s2_q;
	logic                slow_s3_q;
	logic                slow_edge;
	logic [2:0]          tcc_q;
	logic                drive_during_stop_q;
	logic [1:0]          haltm_q;
	logic [2:0]          st_q;
	logic [2:0]          st_d;
	logic [2:0]          mask_q;
	logic [WAKE_W-1:0]   pend_q;
	logic [WAKE_W-1:0]   pend_d;
	logic [WAKE_W-1:0]   wake_ev;
	logic [WAKE_W-1:0]   ack_clr;
	logic [WAKE_W-1:0]   grant;
	logic [WAKE_W:0]     any_below;
	ctt_state_type       state_q;
	ctt_state_type       state_d;
	logic [1:0]          halt_mode_q;
	logic [1:0]          halt_mode_d;
	logic [2:0]          ent_cnt_q;
	logic [15:0]         warm_cnt_q;
	logic                entry_done;
	logic                warm_done;
	logic                hold_mode;
	logic                any_wake;
	logic                tick_pulse;
	logic                wr_tcc;
	logic                wr_sc2;
	logic                wr_mask;
	logic                rd_status;
	logic [7:0]          rd_val;
	logic [7:0]          rdata_q;
	logic                stop_q;
	logic                sysclk_q;
	logic                svc_req_q;
	logic [2:0]          svc_id_q;
	logic                halt_ended;
	logic                warm_finished;

	function automatic logic [2:0] ctt_index(input logic [WAKE_W-1:0] onehot);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 0; i < WAKE_W; i++) begin
			if (onehot[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// Slow clock pin synchroniser and edge detect
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			slow_s1_q <= 1'b0;
			slow_s2_q <= 1'b0;
			slow_s3_q <= 1'b0;
		end else begin
			slow_s1_q <= SLOW_CLK;
			slow_s2_q <= slow_s1_q;
			slow_s3_q <= slow_s2_q;
		end
	end
	assign slow_edge = slow_s2_q && !slow_s3_q;

	ctt_tick_counter u_tick (
		.clk       (CLK),
		.nrst      (NRST),
		.slow_edge (slow_edge),
		.run       (tcc_q[TCC_RUN_BIT]),
		.sel       (tcc_q[TCC_SEL_LSB +: 2]),
		.tick_q    (tick_pulse)
	);
	assign TICK_INTERRUPT = tick_pulse;

	// Register decode
	assign wr_tcc    = REG_WR && (REG_ADDR == ADDR_TICK_CTRL);
	assign wr_sc2    = REG_WR && (REG_ADDR == ADDR_SYS_CTRL2);
	assign wr_mask   = REG_WR && (REG_ADDR == ADDR_INT_MASK);
	assign rd_status = REG_RD && (REG_ADDR == ADDR_INT_STATUS);

	// RULE8 undefined bits read as zero
	assign rd_val = (REG_ADDR == ADDR_TICK_CTRL)  ? {5'h00, tcc_q} :
			(REG_ADDR == ADDR_SYS_CTRL2)  ? {4'h0, haltm_q, 1'b0, drive_during_stop_q} :
			(REG_ADDR == ADDR_INT_STATUS) ? {5'h00, st_q} :
			(REG_ADDR == ADDR_INT_MASK)   ? {5'h00, mask_q} :
			(REG_ADDR == ADDR_WAKE_PEND)  ? {1'b0, pend_q} : 8'h00;

	// RULE10 bit 7 is not stored
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tcc_q   <= TCC_RESET;
			drive_during_stop_q  <= 1'b0;
			haltm_q <= HALTM_RESET;
			mask_q  <= MASK_RESET;
			rdata_q <= 8'h00;
		end else begin
			if (wr_tcc) begin
				tcc_q <= REG_WDATA[2:0];
			end
			if (wr_sc2) begin
				drive_during_stop_q  <= REG_WDATA[SC2_DRIVE_DURING_STOP_BIT];
				haltm_q <= REG_WDATA[SC2_HALTM_LSB +: 2];
			end
			if (wr_mask) begin
				mask_q <= REG_WDATA[2:0];
			end
			rdata_q <= REG_RD ? rd_val : 8'h00;
		end
	end
	assign REG_RDATA = rdata_q;

	// Halt sequence decode
	assign hold_mode  = (halt_mode_q == HALT_STOP) || (halt_mode_q == HALT_LIGHT);
	assign wake_ev    = {tick_pulse, WAKE_IN};
	assign any_wake   = |wake_ev;
	assign entry_done = PRESCALER_TICK && (ent_cnt_q == ENTRY_PRESC_CLKS - 3'h1);
	assign warm_done  = (warm_cnt_q == WARMUP_CYCLES - 16'h0001);
	assign halt_mode_d = (state_q == ST_RUN && HALT_EXEC) ? haltm_q : halt_mode_q;
	assign halt_ended    = (state_q == ST_HALTED) && any_wake;
	assign warm_finished = (state_q == ST_WARMUP) && warm_done;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_RUN: begin
				if (HALT_EXEC) begin
					state_d = ST_ENTER;
				end
			end
			ST_ENTER: begin
				// RULE4 hold wakes in entry window
				if (!hold_mode && any_wake) begin
					state_d = ST_RUN;
				end else if (entry_done) begin
					state_d = ST_HALTED;
				end
			end
			ST_HALTED: begin
				// RULE5 new wake ends halt
				if (any_wake) begin
					state_d = (halt_mode_q == HALT_STOP) ? ST_WARMUP : ST_RUN;
				end
			end
			ST_WARMUP: begin
				// RULE7 warm-up before clock
				if (warm_done) begin
					state_d = ST_RUN;
				end
			end
		endcase
	end

	// Pending wakes, priority grant on next value
	assign ack_clr = WAKE_SERVICE_ACK ? (7'h01 << svc_id_q) : 7'h00;
	assign pend_d  = (pend_q & ~ack_clr) | wake_ev;
	assign any_below[0] = 1'b0;
	generate
		for (genvar i = 0; i < WAKE_W; i++) begin : g_prio
			// RULE5 lowest index wins
			assign grant[i]       = pend_d[i] && !any_below[i];
			assign any_below[i+1] = any_below[i] || pend_d[i];
		end
	endgenerate

	// Sticky status, set wins over read clear
	assign st_d = (st_q & (rd_status ? 3'h0 : 3'h7)) |
			{warm_finished, halt_ended, tick_pulse};
	assign IRQ  = |(st_q & mask_q);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_q     <= ST_RUN;
			halt_mode_q <= HALTM_RESET;
			ent_cnt_q   <= 3'h0;
			warm_cnt_q  <= 16'h0000;
			pend_q      <= PEND_RESET;
			st_q        <= ST_RESET;
		end else begin
			state_q     <= state_d;
			halt_mode_q <= halt_mode_d;
			ent_cnt_q   <= (state_q != ST_ENTER) ? 3'h0 :
					PRESCALER_TICK ? ent_cnt_q + 3'h1 : ent_cnt_q;
			warm_cnt_q  <= (state_q == ST_WARMUP) ? warm_cnt_q + 16'h0001 : 16'h0000;
			pend_q      <= pend_d;
			st_q        <= st_d;
		end
	end

	// Outputs toward halt sequencer and interrupt controller
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			stop_q    <= 1'b0;
			sysclk_q  <= 1'b1;
			svc_req_q <= 1'b0;
			svc_id_q  <= 3'h0;
		end else begin
			// RULE6 stop indication
			stop_q    <= (state_d == ST_ENTER || state_d == ST_HALTED) &&
					(halt_mode_d == HALT_STOP) && !drive_during_stop_q;
			// RULE7 clock only after warm-up
			sysclk_q  <= (state_d != ST_WARMUP) && !(state_d == ST_HALTED &&
					(halt_mode_d == HALT_STOP || halt_mode_d == HALT_LIGHT));
			svc_req_q <= (state_d == ST_RUN) && (|pend_d);
			svc_id_q  <= ctt_index(grant);
		end
	end
	assign STOP             = stop_q;
	assign SYS_CLK_EN       = sysclk_q;
	assign WAKE_SERVICE_REQ = svc_req_q;
	assign WAKE_SERVICE_ID  = svc_id_q;

	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_entry_hold: assert property ((state_q == ST_ENTER && hold_mode && any_wake && !entry_done)
			|=> (state_q == ST_ENTER && (pend_q & $past(wake_ev)) == $past(wake_ev))) // RULE4
		else $error("wake during entry not held");
	a_entry_length: assert property ((state_q == ST_RUN && HALT_EXEC && haltm_q == HALT_LIGHT)
			##1 (!any_wake && !PRESCALER_TICK)[*4] |-> state_q == ST_ENTER) // RULE4
		else $error("halt entry left early");
	a_wake_ends: assert property ((state_q == ST_HALTED && any_wake) |=> state_q != ST_HALTED) // RULE5
		else $error("wake did not end halt");
	a_grant_prio: assert property (svc_req_q |->
			((pend_q & ((7'h01 << svc_id_q) - 7'h01)) == 7'h00 && pend_q[svc_id_q])) // RULE5
		else $error("service id is not highest pending");
	a_stop_level: assert property (STOP |-> (halt_mode_q == HALT_STOP && !$past(drive_during_stop_q))) // RULE6
		else $error("stop high without stop mode");
	a_stop_rise: assert property ((state_q == ST_RUN && HALT_EXEC && haltm_q == HALT_STOP
			&& !drive_during_stop_q) |=> STOP) // RULE6
		else $error("stop not raised on stop halt");
	a_warm_first: assert property ((state_q == ST_HALTED && halt_mode_q == HALT_STOP && any_wake)
			|=> (state_q == ST_WARMUP && !SYS_CLK_EN)) // RULE7
		else $error("stop release skipped warm-up");
	a_warm_clock: assert property ((state_q == ST_WARMUP) |=> (!SYS_CLK_EN || state_q == ST_RUN)) // RULE7
		else $error("clock delivered during warm-up");
	a_ctrl_read: assert property ((REG_RD && REG_ADDR == ADDR_TICK_CTRL)
			|=> (REG_RDATA[7:3] == 5'h00 && REG_RDATA[2:0] == $past(tcc_q))) // RULE8
		else $error("tick control read back wrong");
	a_tick_wake: assert property (tick_pulse |=> pend_q[WAKE_W-1]) // RULE9
		else $error("tick request not recorded");

	c_tick: cover property (tick_pulse && IRQ);
	c_held_wake: cover property (state_q == ST_ENTER && hold_mode && any_wake);
	c_warm_done: cover property (warm_finished);
	c_two_pending: cover property (svc_req_q && $countones(pend_q) > 1);
endmodule

/* rtl/ctt_pkg.sv */
// Constants, field layout and types of the tick timer and halt wake block
package ctt_pkg;
	// Register addresses on the plain register port
	localparam logic [11:0] ADDR_TICK_CTRL   = 12'h310;
	localparam logic [11:0] ADDR_SYS_CTRL2   = 12'h311;
	localparam logic [11:0] ADDR_INT_STATUS  = 12'h312;
	localparam logic [11:0] ADDR_INT_MASK    = 12'h313;
	localparam logic [11:0] ADDR_WAKE_PEND   = 12'h314;
	// Tick timer control fields
	localparam int          TCC_RUN_BIT      = 0;
	localparam int          TCC_SEL_LSB      = 1;
	localparam logic [2:0]  TCC_RESET        = 3'h0;
	// System control two fields
	localparam int          SC2_DRIVE_DURING_STOP_BIT     = 0;
	localparam int          SC2_HALTM_LSB    = 2;
	localparam logic [1:0]  HALTM_RESET      = 2'h0;
	// Halt modes
	localparam logic [1:0]  HALT_STOP        = 2'h1;
	localparam logic [1:0]  HALT_LIGHT       = 2'h2;
	localparam logic [1:0]  HALT_OPER        = 2'h3;
	// Interrupt status bits
	localparam int          ST_TICK          = 0;
	localparam int          ST_WAKE          = 1;
	localparam int          ST_WARM          = 2;
	localparam logic [2:0]  ST_RESET         = 3'h0;
	localparam logic [2:0]  MASK_RESET       = 3'h0;
	// Wake sources: 0 nmi, 1..5 external zero..four, 6 tick; lower index wins
	localparam int          WAKE_EXT_W       = 6;
	localparam int          WAKE_W           = 7;
	localparam logic [6:0]  PEND_RESET       = 7'h00;
	// Tick counter
	localparam int          TICK_CNT_W       = 14;
	localparam logic [13:0] TICK_FULL        = 14'h3fff;
	// Halt entry window in prescaler clocks, warm-up default in CLK cycles
	localparam logic [2:0]  ENTRY_PRESC_CLKS = 3'h5;
	localparam logic [15:0] WARMUP_CYCLES_DEF = 16'h0400;

	typedef enum logic [3:0] {
		ST_RUN    = 4'b0001,
		ST_ENTER  = 4'b0010,
		ST_HALTED = 4'b0100,
		ST_WARMUP = 4'b1000
	} ctt_state_type;
endpackage

/* rtl/ctt_tick_counter.sv */
// Tick counter on slow clock edges with selectable period
`timescale 1ns/1ps
module ctt_tick_counter import ctt_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Control
	input  wire logic        slow_edge,
	input  wire logic        run,
	input  wire logic [1:0]  sel,
	// Result
	output logic             tick_q
);
	logic [TICK_CNT_W-1:0] cnt_q;
	logic [TICK_CNT_W-1:0] cnt_d;
	logic [TICK_CNT_W-1:0] lim;
	logic                  wrap;

	// RULE1 period from selector
	assign lim   = TICK_FULL >> sel;
	// Compare with >= so a shortened period still wraps
	assign wrap  = run && slow_edge && (cnt_q >= lim);
	// RULE2 stop and clear
	assign cnt_d = !run ? '0 : wrap ? '0 : slow_edge ? cnt_q + 14'h0001 : cnt_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			// RULE9 tick request
			tick_q <= wrap;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_tick_wrap: assert property ((run && slow_edge && cnt_q >= lim) |=> (tick_q && cnt_q == 0)) // RULE1
		else $error("tick not raised at end of period");
	a_stop_clear: assert property (!run |=> (cnt_q == 0 && !tick_q)) // RULE2
		else $error("counter not cleared while stopped");
	a_count_step: assert property ((run && slow_edge && cnt_q < lim) |=> cnt_q == $past(cnt_q) + 1) // RULE2
		else $error("counter did not step on slow edge");
endmodule

/* testbench/ctt_partner.sv */
// Halt sequencer and interrupt controller model facing the block
`timescale 1ns/1ps
module ctt_partner (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Pacing of service answers
	input  wire logic [3:0] lag,
	// Sequencer and controller side
	input  wire logic       req,
	output logic            presc_tick,
	output logic            ack
);
	logic [3:0] div_q;
	logic [3:0] wait_q;

	// prescaler clock, one pulse per four cycles
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q      <= 4'h0;
			presc_tick <= 1'b0;
		end else begin
			div_q      <= div_q + 4'h1;
			presc_tick <= (div_q[1:0] == 2'h3);
		end
	end

	// serve pending wakes one at a time, after lag cycles
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_q <= 4'h0;
			ack    <= 1'b0;
		end else begin
			ack <= 1'b0;
			if (req && !ack && wait_q >= lag) begin
				ack    <= 1'b1;
				wait_q <= 4'h0;
			end else if (req && !ack) begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule

/* testbench/ctt_tick_timer_halt_wake_bench.sv */
// Self-checking bench of the tick timer and halt wake block
`timescale 1ns/1ps
module ctt_tick_timer_halt_wake_bench import ctt_pkg::*; ;
	localparam logic [15:0] W = 16'h0008;
	logic        CLK, NRST, REG_WR, REG_RD, SLOW_CLK, HALT_EXEC, PRESCALER_TICK;
	logic        STOP, SYS_CLK_EN, TICK_INTERRUPT, WAKE_SERVICE_REQ, WAKE_SERVICE_ACK, IRQ;
	logic [11:0] REG_ADDR;
	logic [7:0]  REG_WDATA, REG_RDATA, v;
	logic [5:0]  WAKE_IN;
	logic [2:0]  WAKE_SERVICE_ID;
	logic [3:0]  lag;
	logic [2:0]  acks[$];
	int          error_cnt, checked, seed, ticks, n, e;

	ctt_tick_timer_halt_wake #(.WARMUP_CYCLES(W)) dut (.CLK(CLK), .NRST(NRST),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .SLOW_CLK(SLOW_CLK), .HALT_EXEC(HALT_EXEC),
		.PRESCALER_TICK(PRESCALER_TICK), .STOP(STOP), .SYS_CLK_EN(SYS_CLK_EN),
		.WAKE_IN(WAKE_IN), .TICK_INTERRUPT(TICK_INTERRUPT),
		.WAKE_SERVICE_REQ(WAKE_SERVICE_REQ), .WAKE_SERVICE_ID(WAKE_SERVICE_ID),
		.WAKE_SERVICE_ACK(WAKE_SERVICE_ACK), .IRQ(IRQ));
	ctt_partner peer (.clk(CLK), .nrst(NRST), .lag(lag), .req(WAKE_SERVICE_REQ),
		.presc_tick(PRESCALER_TICK), .ack(WAKE_SERVICE_ACK));

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	// Slow clock at half the bus clock, served order and tick count
	always @(posedge CLK) begin
		SLOW_CLK <= ~SLOW_CLK;
		if (WAKE_SERVICE_ACK)
			acks.push_back(WAKE_SERVICE_ID);
		if (TICK_INTERRUPT)
			ticks++;
	end

	task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] g);
		checked++;
		if (g !== ex) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_WR    <= 1'b1;
		REG_ADDR  <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] ex, input string nm);
		@(posedge CLK);
		REG_RD   <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 cmp(nm, {8'h00, ex}, {8'h00, REG_RDATA});
	endtask
	task automatic pulse(input int s);
		@(posedge CLK);
		WAKE_IN[s] <= 1'b1;
		@(posedge CLK);
		WAKE_IN <= 6'h00;
	endtask
	task automatic wait_for(input bit clk_en, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge CLK);
			#1 cnt++;
		end while ((clk_en ? SYS_CLK_EN : TICK_INTERRUPT) !== 1'b1 && cnt < lim);
	endtask
	task automatic halt_case(input logic [1:0] m, input logic d);
		int a;
		int b;
		int k;
		int lo;
		bit held;
		a = {$random(seed)} % 6;
		b = (a + 1 + {$random(seed)} % 5) % 6;
		held = (m == HALT_STOP || m == HALT_LIGHT);
		// Wake seen one edge before the count starts, so stop exit shows W, checked from W-1
		lo = (m == HALT_STOP) ? int'(W) - 1 : 1;
		lag <= 4'($random(seed));
		wr(ADDR_SYS_CTRL2, (8'(m) << SC2_HALTM_LSB) | (8'(d) << SC2_DRIVE_DURING_STOP_BIT));
		acks = {};
		@(posedge CLK);
		HALT_EXEC <= 1'b1;
		@(posedge CLK);
		HALT_EXEC <= 1'b0;
		pulse(a);
		#1 cmp("stop", {15'h0, m == HALT_STOP && !d}, {15'h0, STOP});
		repeat (40) @(posedge CLK);
		#1 cmp("clock running", {15'h0, !held}, {15'h0, SYS_CLK_EN});
		if (held) begin
			cmp("early served", 16'h0, 16'(acks.size()));
			pulse(b);
			wait_for(1'b1, 200, k);
			cmp("exit delay", 16'h1, {15'h0, k >= lo && k <= lo + 4});
			cmp("stop released", 16'h0, {15'h0, STOP});
		end
		repeat (50) @(posedge CLK);
		cmp("served count", held ? 16'h2 : 16'h1, 16'(acks.size()));
		cmp("first served", 16'(held && b < a ? b : a), {13'h0, acks[0]});
		if (held) begin
			cmp("second served", 16'(b < a ? a : b), {13'h0, acks[1]});
			rd(ADDR_INT_STATUS, (m == HALT_STOP) ? 8'h06 : 8'h02, "status");
		end
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#(95000 * 25);
		error_cnt++;
		complete_run();
	end

	initial begin
		seed = 32'hd4fe;
		{NRST, REG_WR, REG_RD, HALT_EXEC, SLOW_CLK} = 5'h00;
		REG_ADDR = 12'h000;
		REG_WDATA = 8'h00;
		WAKE_IN = 6'h00;
		lag = 4'h0;
		{error_cnt, checked, ticks} = '0;
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		for (int a = 0; a < 5; a++)
			rd(ADDR_TICK_CTRL + 12'(a), 8'h00, "reset value");
		repeat (4) begin
			v = 8'($random(seed)) & 8'h7f;
			wr(ADDR_TICK_CTRL, v);
			rd(ADDR_TICK_CTRL, v & 8'h07, "tick control");
			wr(ADDR_SYS_CTRL2, v);
			rd(ADDR_SYS_CTRL2, v & 8'h0d, "system control two");
			wr(ADDR_INT_MASK, v);
			rd(ADDR_INT_MASK, v & 8'h07, "mask");
		end
		for (int a = 4; a < 6; a++) begin
			wr(ADDR_TICK_CTRL + 12'(a), 8'hff);
			rd(ADDR_TICK_CTRL + 12'(a), 8'h00, "read only or unmapped");
		end
		wr(ADDR_INT_MASK, 8'h00);
		wr(ADDR_TICK_CTRL, 8'h00);
		for (int i = 4; i >= 0; i--)
			halt_case(2'(10'b11_00_10_01_01 >> (2 * i)), 1'(5'b01010 >> i));
		wr(ADDR_SYS_CTRL2, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_TICK_CTRL, 8'h00);
			wr(ADDR_TICK_CTRL, 8'(s << TCC_SEL_LSB) | 8'h01);
			wait_for(1'b0, 70000, n);
			e = 1 << (15 - s);
			cmp("first tick", 16'h1, {15'h0, n >= e - 3 && n <= e + 6});
		end
		acks = {};
		wait_for(1'b0, 9000, n);
		cmp("tick period", 16'h1000, 16'(n));
		cmp("masked irq", 16'h0, {15'h0, IRQ});
		wr(ADDR_INT_MASK, 8'h01);
		#1 cmp("irq", 16'h1, {15'h0, IRQ});
		rd(ADDR_INT_STATUS, 8'h01, "tick status");
		#1 cmp("irq cleared", 16'h0, {15'h0, IRQ});
		repeat (20) @(posedge CLK);
		cmp("tick served", 16'h6, {13'h0, acks[0]});
		repeat (2000) @(posedge CLK);
		wr(ADDR_TICK_CTRL, 8'h06);
		ticks = 0;
		repeat (5000) @(posedge CLK);
		cmp("stopped ticks", 16'h0, 16'(ticks));
		wr(ADDR_TICK_CTRL, 8'h07);
		wait_for(1'b0, 9000, n);
		cmp("restart", 16'h1, {15'h0, n >= 4093 && n <= 4102});
		complete_run();
	end
endmodule
